// >>> src/rmn_node.v
/*
  Ring memory node: bus slave with jumper decode, local memory, receive
  and transmit buffers, loop removal and redundant link sending.
  Assumes link neighbours clocked by mclk and an Avalon-MM master.
*/
// The address map and the Avalon-MM interface to the registers were decided locally.
// How it works
// - Compare A31..A24 with extended jumpers only when extended enable fitted.
// - A fitted jumper reads as zero, an open one as one.
// - Standard match on A23..A20, A23..A19 or A23..A18 by memory size.
// - Node identity is the eight node jumpers, fitted meaning zero.
// - Accept supervisory data, nonprivileged data, or both, as selected.
// - Rate jumper fitted sends every link word twice.
// - Redundant mode: bad first copy dropped, second used; good first skips second.
// - Error raises local status interrupt only with mask jumper fitted.
// - Status bit 3 set on any single transfer error.
// - Status shows half-full and transfer error as separate causes.
// - Received word tagged with own identity is removed from the ring.
// - Removing an own returned word sets the loop-return flag.
// - Writing zero clears loop-return flag; write travels ring, others unaffected.
// - Foreign words enter receive buffer, then transmit buffer, and memory if a memory word.
// - Host writes may slot between received words by arrival.
// - Simultaneous host and link requests: host granted first.
// - Otherwise a late requester waits for the current cycle to end.
// - Host write with transmit buffer over half but not full raises local status interrupt.
// - Host write with transmit buffer full answers bus error.
`timescale 1ns/10ps
`include "rmn_regs.vh"
module rmn_node #(
  parameter MEM_AW = 18,
  parameter FIFO_AW = 9,
  parameter [7:0] BOARD_ID = 8'h5a  // Arbitrary value
) (
  input wire mclk,
  input wire nrst,
  input wire [31:0] avsAddress,
  input wire [5:0] avsAm,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  input wire [3:0] avsByteenable,
  output reg [31:0] avsReaddata,
  output reg [1:0] avsResponse,
  output reg avsWaitrequest,
  input wire [7:0] extAddrMatchJumpers,
  input wire extAddrEnableJumperN,
  input wire [5:0] stdAddrMatchJumpers,
  input wire [1:0] memSizeSel,
  input wire [7:0] nodeIdentityJumpers,
  input wire [1:0] addrModifierSelectJumpersN,
  input wire linkRateSelectJumperN,
  input wire errorIrqMaskJumperN,
  input wire rxValid,
  input wire [MEM_AW+44:0] rxData,
  input wire rxErr,
  output reg rxReady,
  output reg txValid,
  output reg [MEM_AW+44:0] txData,
  input wire txReady,
  output reg localStatusIrqInput
);
  localparam LW = MEM_AW + 45;
  localparam AL = `RMN_DW;
  localparam BL = AL + MEM_AW;
  localparam TL = BL + `RMN_BEW;
  localparam KB = TL + `RMN_TAGW;
  localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};
  localparam [FIFO_AW:0] HALF = {2'b01, {(FIFO_AW-1){1'b0}}};
  localparam [FIFO_AW:0] RX_LIMIT = DEPTH - {{(FIFO_AW-1){1'b0}}, 2'b10};
  localparam JW = 29;
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_ACK = 3'b010;
  localparam [2:0] S_LINK = 3'b100;

  // ----------------------------------------------------------------
  // Jumper synchroniser
  // ----------------------------------------------------------------
  reg [JW-1:0] jmpMeta_q;
  reg [JW-1:0] jmp_q;
  wire [JW-1:0] jmpPins = {extAddrMatchJumpers, extAddrEnableJumperN,
    stdAddrMatchJumpers, memSizeSel, nodeIdentityJumpers,
    addrModifierSelectJumpersN, linkRateSelectJumperN, errorIrqMaskJumperN};
  wire [7:0] extMatch = jmp_q[28:21];
  wire extEnable = ~jmp_q[20];
  wire [5:0] stdMatch = jmp_q[19:14];
  wire [1:0] memSize = jmp_q[13:12];
  wire [7:0] nodeId = jmp_q[11:4];
  wire supAllowed = ~jmp_q[2];
  wire npAllowed = ~jmp_q[3];
  wire redundant = ~jmp_q[1];
  wire errMaskFitted = ~jmp_q[0];

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      jmpMeta_q <= {JW{1'b1}};
      jmp_q <= {JW{1'b1}};
    end else begin
      jmpMeta_q <= jmpPins;
      jmp_q <= jmpMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  reg [5:0] stdMask;
  always @* begin
    case (memSize)
      `RMN_MEM_1M: stdMask = `RMN_STD_MASK_1M;
      `RMN_MEM_512K: stdMask = `RMN_STD_MASK_512K;
      default: stdMask = `RMN_STD_MASK_256K;
    endcase
  end

  wire stdHit = (((avsAddress[`RMN_STD_HI:`RMN_STD_LO] ^ stdMatch) & stdMask) == 6'h00);
  wire extHit = !extEnable || (avsAddress[`RMN_EXT_HI:`RMN_EXT_LO] == extMatch);
  wire [2:0] amSpace = extEnable ? `RMN_AM_SPACE_A32 : `RMN_AM_SPACE_A24;
  wire amOk = (avsAm[5:3] == amSpace) &&
    (((avsAm[2:0] == `RMN_AM_SUP_DATA) && supAllowed) ||
     ((avsAm[2:0] == `RMN_AM_NP_DATA) && npAllowed));
  wire hit = stdHit && extHit && amOk;
  wire regArea = (avsAddress[MEM_AW+1:`RMN_REG_AREA_LSB] == {(MEM_AW-4){1'b0}});
  wire [3:0] regIdx = avsAddress[5:2];
  wire [MEM_AW-1:0] memIdx = avsAddress[MEM_AW+1:2];
  wire hostReq = avsRead || avsWrite;

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  reg rxPush;
  wire rxWrReady;
  wire rxAvail;
  wire [LW-1:0] rxWord;
  reg rxPop;
  wire [FIFO_AW:0] rxCount;
  reg txPush;
  reg [LW-1:0] txPushWord;
  wire txWrReady;
  wire txAvail;
  wire [LW-1:0] txWord;
  wire txLoad;
  wire [FIFO_AW:0] txCount;

  rmn_fifo #(.W(LW), .AW(FIFO_AW)) rxBuf (
    .mclk(mclk),
    .nrst(nrst),
    .wrValid(rxPush),
    .wrData(rxData),
    .wrReady(rxWrReady),
    .rdValid(rxAvail),
    .rdData(rxWord),
    .rdReady(rxPop),
    .count(rxCount)
  );

  rmn_fifo #(.W(LW), .AW(FIFO_AW)) txBuf (
    .mclk(mclk),
    .nrst(nrst),
    .wrValid(txPush),
    .wrData(txPushWord),
    .wrReady(txWrReady),
    .rdValid(txAvail),
    .rdData(txWord),
    .rdReady(txLoad),
    .count(txCount)
  );

  wire txOverHalf = (txCount > HALF);
  wire rxUnderHalf = (rxCount < HALF);

  // ----------------------------------------------------------------
  // Link receive: pairing, error and own-word removal
  // ----------------------------------------------------------------
  reg rxSecond_q;
  reg rxFirstBad_q;
  reg accept;
  wire rxFire = rxValid && rxReady;
  wire ownWord = (rxData[KB-1:TL] == nodeId);
  wire errEvent = rxFire && rxErr;

  always @* begin
    accept = 1'b0;
    if (rxFire) begin
      if (!redundant || !rxSecond_q) begin
        accept = !rxErr;
      end else begin
        accept = rxFirstBad_q && !rxErr;
      end
    end
    rxPush = accept && !ownWord && rxWrReady;
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxSecond_q <= 1'b0;
      rxFirstBad_q <= 1'b0;
      rxReady <= 1'b0;
    end else begin
      rxReady <= (rxCount < RX_LIMIT);
      if (!redundant) begin
        rxSecond_q <= 1'b0;
      end else if (rxFire) begin
        rxSecond_q <= !rxSecond_q;
        rxFirstBad_q <= rxErr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory and arbitration
  // ----------------------------------------------------------------
  reg [31:0] mem [0:(1<<MEM_AW)-1];
  reg [2:0] state_q;
  reg [7:0] csr_q;
  reg memWr;
  reg [MEM_AW-1:0] memWrIdx;
  reg [31:0] memWrData;
  reg [3:0] memWrBe;
  reg hostWrOk;
  reg csrWr;
  reg [1:0] resp;
  reg [31:0] rdata;
  wire [7:0] csrView;
  integer b;

  assign csrView = {1'b0, rxUnderHalf, !txOverHalf, txAvail, csr_q[3:0]};

  always @* begin
    memWr = 1'b0;
    memWrIdx = memIdx;
    memWrData = avsWritedata;
    memWrBe = avsByteenable;
    hostWrOk = 1'b0;
    csrWr = 1'b0;
    resp = `RMN_RESP_OKAY;
    rdata = 32'h0000_0000;
    txPush = 1'b0;
    txPushWord = {`RMN_KIND_MEM, nodeId, avsByteenable, memIdx, avsWritedata};
    rxPop = 1'b0;
    if (state_q == S_IDLE) begin
      if (hostReq) begin
        if (!hit) begin
          resp = `RMN_RESP_DECERR;
        end else if (avsWrite && !txWrReady) begin
          resp = `RMN_RESP_SLVERR;
        end else if (avsWrite) begin
          hostWrOk = 1'b1;
          if (!regArea) begin
            memWr = 1'b1;
            txPush = 1'b1;
          end else if (regIdx == `RMN_IDX_CSR) begin
            csrWr = avsByteenable[0];
            txPush = avsByteenable[0];
            txPushWord[KB] = `RMN_KIND_REG;
          end
        end else if (!regArea) begin
          rdata = mem[memIdx];
        end else begin
          case (regIdx)
            `RMN_IDX_BOARD_ID: rdata = {24'h000000, BOARD_ID};
            `RMN_IDX_NODE_ID: rdata = {24'h000000, nodeId};
            `RMN_IDX_CSR: rdata = {24'h000000, csrView};
            default: rdata = 32'h0000_0000;
          endcase
        end
      end else if (rxAvail && txWrReady) begin
        rxPop = 1'b1;
        txPush = 1'b1;
        txPushWord = rxWord;
        memWr = (rxWord[KB] == `RMN_KIND_MEM);
        memWrIdx = rxWord[BL-1:AL];
        memWrData = rxWord[AL-1:0];
        memWrBe = rxWord[TL-1:BL];
      end
    end
  end

  always @(posedge mclk) begin
    if (memWr) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (memWrBe[b]) begin
          mem[memWrIdx][b*8 +: 8] <= memWrData[b*8 +: 8];
        end
      end
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      avsWaitrequest <= 1'b1;
      avsReaddata <= 32'h0000_0000;
      avsResponse <= `RMN_RESP_OKAY;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (hostReq) begin
            state_q <= S_ACK;
            avsWaitrequest <= 1'b0;
            avsReaddata <= rdata;
            avsResponse <= resp;
          end else if (rxPop) begin
            state_q <= S_LINK;
          end
        end
        S_ACK: begin
          state_q <= S_IDLE;
          avsWaitrequest <= 1'b1;
        end
        S_LINK: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
          avsWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags and local status interrupt
  // ----------------------------------------------------------------
  wire loopSet = accept && ownWord;
  wire loopClr = csrWr && !avsWritedata[`RMN_CSR_LOOP_RETURN];
  wire errClr = csrWr && !avsWritedata[`RMN_CSR_XFER_ERR];

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      csr_q <= `RMN_CSR_RESET;
      localStatusIrqInput <= 1'b0;
    end else begin
      if (loopSet) begin
        csr_q[`RMN_CSR_LOOP_RETURN] <= 1'b1;
      end else if (loopClr) begin
        csr_q[`RMN_CSR_LOOP_RETURN] <= 1'b0;
      end
      if (errEvent) begin
        csr_q[`RMN_CSR_XFER_ERR] <= 1'b1;
      end else if (errClr) begin
        csr_q[`RMN_CSR_XFER_ERR] <= 1'b0;
      end
      localStatusIrqInput <= (hostWrOk && txOverHalf) ||
        (errEvent && errMaskFitted);
    end
  end

  // ----------------------------------------------------------------
  // Link transmit, each word twice in redundant mode
  // ----------------------------------------------------------------
  reg txCopy_q;
  wire txFire = txValid && txReady;
  wire txRepeat = redundant && !txCopy_q;
  assign txLoad = txAvail && (!txValid || (txFire && !txRepeat));

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txValid <= 1'b0;
      txData <= {LW{1'b0}};
      txCopy_q <= 1'b0;
    end else if (txFire && txRepeat) begin
      txCopy_q <= 1'b1;
    end else if (txFire || !txValid) begin
      txCopy_q <= 1'b0;
      txValid <= txAvail;
      if (txAvail) begin
        txData <= txWord;
      end
    end
  end
endmodule

// >>> src/rmn_regs.vh
/*
  Shared constants of the ring memory node: register indices, status bits,
  decode masks, address modifier codes, bus answers and link word widths.
  Assumes inclusion by the node, its checker and its bench only.
*/
`ifndef RMN_REGS_VH
`define RMN_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RMN_IDX_BOARD_ID 4'h1
`define RMN_IDX_NODE_ID 4'h4
`define RMN_IDX_CSR 4'h5
`define RMN_REG_AREA_LSB 6

// ----------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------
`define RMN_CSR_RX_UNDER_HALF 6
`define RMN_CSR_TX_UNDER_HALF 5
`define RMN_CSR_TX_NOT_EMPTY 4
`define RMN_CSR_XFER_ERR 3
`define RMN_CSR_LOOP_RETURN 0
`define RMN_CSR_RESET 8'h00

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
`define RMN_MEM_1M 2'h0
`define RMN_MEM_512K 2'h1
`define RMN_STD_MASK_1M 6'h3c
`define RMN_STD_MASK_512K 6'h3e
`define RMN_STD_MASK_256K 6'h3f
`define RMN_STD_HI 23
`define RMN_STD_LO 18
`define RMN_EXT_HI 31
`define RMN_EXT_LO 24
`define RMN_AM_SPACE_A32 3'h1
`define RMN_AM_SPACE_A24 3'h7
`define RMN_AM_SUP_DATA 3'h5
`define RMN_AM_NP_DATA 3'h1

// ----------------------------------------------------------------
// Bus answers and link word
// ----------------------------------------------------------------
`define RMN_RESP_OKAY 2'h0
`define RMN_RESP_SLVERR 2'h2
`define RMN_RESP_DECERR 2'h3
`define RMN_DW 32
`define RMN_BEW 4
`define RMN_TAGW 8
`define RMN_KIND_MEM 1'b0
`define RMN_KIND_REG 1'b1

`endif

// >>> src/rmn_fifo.v
/*
  Synchronous first-in first-out buffer with valid/ready on both sides
  and an occupancy count.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module rmn_fifo #(
  parameter W = 64,
  parameter AW = 9
) (
  input wire mclk,
  input wire nrst,
  input wire wrValid,
  input wire [W-1:0] wrData,
  output wire wrReady,
  output wire rdValid,
  output wire [W-1:0] rdData,
  input wire rdReady,
  output wire [AW:0] count
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire doWr;
  wire doRd;

  assign count = wrPtr_q - rdPtr_q;
  assign wrReady = (count[AW] == 1'b0);
  assign rdValid = (wrPtr_q != rdPtr_q);
  assign rdData = mem[rdPtr_q[AW-1:0]];
  assign doWr = wrValid & wrReady;
  assign doRd = rdReady & rdValid;

  always @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_q[AW-1:0]] <= wrData;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// >>> test/rmn_node_props.sv
/*
  Checker of the ring node bus and link ports.
  Assumes jumpers held steady around requests and a bind into rmn_node.
*/
`timescale 1ns/10ps
`include "rmn_regs.vh"
module rmn_node_props #(
  parameter MEM_AW = 18,
  parameter FIFO_AW = 9
) (
  input wire mclk,
  input wire nrst,
  input wire [31:0] avsAddress,
  input wire [5:0] avsAm,
  input wire avsRead,
  input wire avsWrite,
  input wire [1:0] avsResponse,
  input wire avsWaitrequest,
  input wire [7:0] extAddrMatchJumpers,
  input wire extAddrEnableJumperN,
  input wire [5:0] stdAddrMatchJumpers,
  input wire [1:0] memSizeSel,
  input wire linkRateSelectJumperN,
  input wire errorIrqMaskJumperN,
  input wire rxValid,
  input wire rxErr,
  input wire rxReady,
  input wire txValid,
  input wire [MEM_AW+44:0] txData,
  input wire txReady,
  input wire localStatusIrqInput
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire ans = !avsWaitrequest && (avsRead || avsWrite);
  wire [5:0] stdMask = memSizeSel == `RMN_MEM_1M ? `RMN_STD_MASK_1M :
    memSizeSel == `RMN_MEM_512K ? `RMN_STD_MASK_512K : `RMN_STD_MASK_256K;
  reg oddQ;
  reg [MEM_AW+44:0] firstQ;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oddQ <= 1'b0;
      firstQ <= {(MEM_AW+45){1'b0}};
    end else if (linkRateSelectJumperN) begin
      oddQ <= 1'b0;
    end else if (txValid && txReady) begin
      oddQ <= !oddQ;
      firstQ <= txData;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  ans_bound_a: assert property ($rose(avsRead || avsWrite) |-> ##[1:2] !avsWaitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avsWaitrequest |-> (avsRead || avsWrite) ##1 avsWaitrequest)
    else $error("answer without request or too long");
  std_match_a: assert property (ans && (((avsAddress[23:18] ^ stdAddrMatchJumpers) & stdMask) != 6'h00)
    |-> avsResponse == `RMN_RESP_DECERR) else $error("standard mismatch accepted");
  ext_match_a: assert property (ans && !extAddrEnableJumperN
    && avsAddress[31:24] != extAddrMatchJumpers |-> avsResponse == `RMN_RESP_DECERR)
    else $error("extended mismatch accepted");
  am_code_a: assert property (ans && avsAm[2:0] != `RMN_AM_SUP_DATA
    && avsAm[2:0] != `RMN_AM_NP_DATA |-> avsResponse == `RMN_RESP_DECERR)
    else $error("bad modifier accepted");
  err_irq_a: assert property (rxValid && rxReady && rxErr && !errorIrqMaskJumperN
    |-> ##[1:3] localStatusIrqInput) else $error("error raised no interrupt");
  redund_copy_a: assert property (txValid && txReady && oddQ |-> txData == firstQ)
    else $error("second copy differs");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("link word dropped before taken");
endmodule
bind rmn_node rmn_node_props #(.MEM_AW(MEM_AW), .FIFO_AW(FIFO_AW)) props (.mclk, .nrst,
  .avsAddress, .avsAm, .avsRead, .avsWrite, .avsResponse, .avsWaitrequest,
  .extAddrMatchJumpers, .extAddrEnableJumperN, .stdAddrMatchJumpers, .memSizeSel,
  .linkRateSelectJumperN, .errorIrqMaskJumperN, .rxValid, .rxErr, .rxReady, .txValid,
  .txData, .txReady, .localStatusIrqInput);

// >>> test/rmn_ring_model.sv
/*
  Neighbour ring node: feeds link words to the node, collects its output.
  Assumes the node's clock; stall makes it a slow receiver.
*/
`timescale 1ns/10ps
module rmn_ring_model #(
  parameter W = 53
) (
  input wire mclk,
  output logic rxValid,
  output logic [W-1:0] rxData,
  output logic rxErr,
  input wire rxReady,
  input wire txValid,
  input wire [W-1:0] txData,
  output logic txReady,
  input wire stall
);
  logic [W-1:0] q[$];
  initial begin
    rxValid = 1'b0;
    rxData = '0;
    rxErr = 1'b0;
    txReady = 1'b0;
  end
  always @(posedge mclk) begin
    txReady <= !stall;
    if (txValid && txReady) begin
      q.push_back(txData);
    end
  end
  task send(input logic [W-1:0] w, input logic e);
    int n;
    @(posedge mclk);
    rxValid <= 1'b1;
    rxData <= w;
    rxErr <= e;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rxReady !== 1'b1 && n < 100);
    // Released lines show garbage, not the last word
    rxValid <= 1'b0;
    rxData <= ~w;
    rxErr <= !e;
  endtask
endmodule

// >>> test/rmn_node_tb.sv
/*
  Self-checking bench of the ring node, one task per scenario.
  Assumes small memory and buffer sizes and the neighbour model.
*/
`timescale 1ns/10ps
`include "rmn_regs.vh"
module rmn_node_tb;
  localparam W = 53;
  localparam [7:0] ID = 8'hc5;
  logic mclk, nrst, avsRead, avsWrite, avsWaitrequest, extAddrEnableJumperN, stall;
  logic linkRateSelectJumperN, errorIrqMaskJumperN, rxValid, rxErr, rxReady, txValid;
  logic txReady, localStatusIrqInput;
  logic [31:0] avsAddress, avsWritedata, avsReaddata, rdV;
  logic [5:0] avsAm, stdAddrMatchJumpers;
  logic [3:0] avsByteenable;
  logic [1:0] avsResponse, rsp, memSizeSel, addrModifierSelectJumpersN;
  logic [7:0] extAddrMatchJumpers, nodeIdentityJumpers;
  logic [W-1:0] rxData, txData;
  int fail_count = 0;
  int checks_done = 0;
  int irqs = 0;
  rmn_node #(.MEM_AW(8), .FIFO_AW(3)) dut (.mclk, .nrst, .avsAddress, .avsAm, .avsRead,
    .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsResponse, .avsWaitrequest,
    .extAddrMatchJumpers, .extAddrEnableJumperN, .stdAddrMatchJumpers, .memSizeSel,
    .nodeIdentityJumpers, .addrModifierSelectJumpersN, .linkRateSelectJumperN,
    .errorIrqMaskJumperN, .rxValid, .rxData, .rxErr, .rxReady, .txValid, .txData, .txReady,
    .localStatusIrqInput);
  rmn_ring_model #(.W(W)) m (.mclk, .rxValid, .rxData, .rxErr, .rxReady, .txValid, .txData,
    .txReady, .stall);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (localStatusIrqInput === 1'b1) irqs <= irqs + 1;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avsWrite <= w;
    avsRead <= !w;
    avsAddress <= a;
    avsWritedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rdV = avsReaddata;
    rsp = avsResponse;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task wq(input int k);
    int i;
    i = 0;
    while (m.q.size() < k && i < 200) begin
      @(posedge mclk);
      i++;
    end
  endtask
  task jw;
    repeat (4) @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_dec;
    for (int s = 0; s < 3; s++) begin
      memSizeSel <= s[1:0];
      jw();
      bus(1, 32'h80080, 0); chk("a19", rsp, s == 0 ? 2'h0 : 2'h3);
      bus(1, 32'h40080, 0); chk("a18", rsp, s < 2 ? 2'h0 : 2'h3);
    end
    stdAddrMatchJumpers <= 6'h20; jw();
    bus(1, 32'h800080, 0); chk("a23", rsp, 2'h0);
    bus(1, 32'h80, 0); chk("a23z", rsp, 2'h3);
    stdAddrMatchJumpers <= 6'h00;
    extAddrEnableJumperN <= 1'b0; extAddrMatchJumpers <= 8'h3c; avsAm <= 6'h0d; jw();
    bus(1, 32'h3c000080, 0); chk("ext", rsp, 2'h0);
    bus(1, 32'h3d000080, 0); chk("extx", rsp, 2'h3);
    extAddrEnableJumperN <= 1'b1;
    for (int j = 1; j < 4; j++) begin
      addrModifierSelectJumpersN <= ~j[1:0]; jw();
      avsAm <= 6'h3d; bus(1, 32'h80, 0); chk("sup", rsp, j[0] ? 2'h0 : 2'h3);
      avsAm <= 6'h39; bus(1, 32'h80, 0); chk("np", rsp, j[1] ? 2'h0 : 2'h3);
    end
    avsAm <= 6'h3d;
    jw();
  endtask
  task t_link;
    logic [W-1:0] w;
    w = {1'b0, 8'h07, 4'hf, 8'h30, 32'hcafe0001};
    m.q.delete(); m.send(w, 1'b0); wq(1);
    chk("fwd", m.q[0], w);
    bus(0, 32'hc0, 0); chk("mem", rdV, 32'hcafe0001);
    m.q.delete(); bus(1, 32'hc4, 32'h5a5a0102); wq(1);
    chk("tag", m.q[0], {1'b0, ID, 4'hf, 8'h31, 32'h5a5a0102});
    bus(0, 32'h10, 0); chk("nid", rdV, {24'h000000, ID});
  endtask
  task t_loop;
    m.q.delete(); bus(1, 32'h14, 0); wq(1);
    chk("csrw", m.q[0][W-1], 1'b1);
    bus(0, 32'h14, 0); chk("lr0", rdV[0], 1'b0);
    m.send({1'b0, ID, 4'hf, 8'h32, 32'h1}, 1'b0); repeat (10) @(posedge mclk);
    chk("rm", m.q.size(), 1);
    bus(0, 32'h14, 0); chk("lr1", rdV[0], 1'b1);
    m.send({1'b1, 8'h07, 4'h1, 8'h05, 32'h0}, 1'b0); wq(2);
    bus(0, 32'h14, 0); chk("lr2", rdV[0], 1'b1);
    bus(1, 32'h14, 0); bus(0, 32'h14, 0); chk("lr3", rdV[0], 1'b0);
  endtask
  task t_err;
    int c;
    errorIrqMaskJumperN <= 1'b0; jw(); c = irqs;
    m.send({1'b0, 8'h07, 4'hf, 8'h33, 32'h2}, 1'b1); repeat (6) @(posedge mclk);
    chk("irq", irqs - c, 1);
    bus(0, 32'h14, 0); chk("err", rdV[3], 1'b1);
    chk("half", rdV[5], 1'b1);
    bus(1, 32'h14, 0); errorIrqMaskJumperN <= 1'b1; jw(); c = irqs;
    bus(0, 32'h14, 0); chk("errc", rdV[3], 1'b0);
    m.send({1'b0, 8'h07, 4'hf, 8'h33, 32'h3}, 1'b1); repeat (6) @(posedge mclk);
    chk("noirq", irqs - c, 0);
    bus(0, 32'h14, 0); chk("err2", rdV[3], 1'b1);
  endtask
  task t_red;
    m.q.delete(); linkRateSelectJumperN <= 1'b0; jw();
    bus(1, 32'hd0, 32'h77); wq(2);
    chk("cp1", m.q[0], {1'b0, ID, 4'hf, 8'h34, 32'h77});
    chk("cp2", m.q[1], {1'b0, ID, 4'hf, 8'h34, 32'h77});
    m.send({1'b0, 8'h07, 4'hf, 8'h35, 32'hbad}, 1'b1);
    m.send({1'b0, 8'h07, 4'hf, 8'h35, 32'h600d}, 1'b0);
    m.send({1'b0, 8'h07, 4'hf, 8'h36, 32'h1111}, 1'b0);
    m.send({1'b0, 8'h07, 4'hf, 8'h36, 32'h2222}, 1'b0);
    repeat (12) @(posedge mclk);
    bus(0, 32'hd4, 0); chk("2nd", rdV, 32'h600d);
    bus(0, 32'hd8, 0); chk("1st", rdV, 32'h1111);
    linkRateSelectJumperN <= 1'b1; jw();
  endtask
  task t_full;
    int c;
    stall <= 1'b1; c = irqs; m.q.delete();
    for (int i = 0; i < 12; i++) bus(1, 32'h100 + i * 4, i);
    chk("berr", rsp, 2'h2);
    chk("hirq", irqs > c, 1'b1);
    stall <= 1'b0; wq(9);
    chk("drain", m.q.size() > 7, 1'b1);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0; avsRead = 1'b0; avsWrite = 1'b0; avsAddress = '0; avsWritedata = '0;
    avsAm = 6'h3d; avsByteenable = 4'hf; extAddrMatchJumpers = 8'hff; stall = 1'b0;
    extAddrEnableJumperN = 1'b1; stdAddrMatchJumpers = 6'h00; memSizeSel = 2'h0;
    nodeIdentityJumpers = ID; addrModifierSelectJumpersN = 2'b00;
    linkRateSelectJumperN = 1'b1; errorIrqMaskJumperN = 1'b1;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_dec(); $display("decode done");
    t_link(); $display("link done");
    t_loop(); $display("loop done");
    t_err(); $display("error done");
    t_red(); $display("redundant done");
    t_full(); $display("full done");
    give_verdict();
  end
endmodule
